// >>> hw/pdm_pkg.sv
// Constants and types for the pulse dimming and pump mode controller
// Function
// - Power-up starts pump at unity gain, stays while channels regulate.
// - Lost regulation steps pump up only after about 400 us delay.
// - Pump steps one at a time: 1x, 1.33x, 1.5x, 2x.
// - Headroom detected in higher mode returns pump directly to unity.
// - Dimming level starts at full scale, 100 percent.
// - One enable/dimming pin both enables driver and carries dimming pulses.
// - Each qualifying rising edge halves current, six levels down to 3.125 percent.
// - Low pulses shorter than 0.2 us may be filtered and ignored.
// - Low pulses beyond 100 us may shut device down instead of dimming.
// - Pin low continuously for 1.5 ms forces zero-current shutdown.
// - LED current settles to new level within typically 40 us.
package pdm_pkg;
  // Clock rate in kHz
  localparam int unsigned CLK_KHZ = 25000;
  // Times in nanoseconds as printed
  localparam int unsigned PROG_LOW_MIN_NS = 200;
  localparam int unsigned SHUTDOWN_LOW_NS = 1500000;
  localparam int unsigned PUMP_DELAY_NS = 400000;
  localparam int unsigned SETTLE_NS = 40000;
  // Least times round up, at least one cycle
  localparam int unsigned LOW_MIN_CYC_RAW = (PROG_LOW_MIN_NS * (CLK_KHZ / 1000) + 999) / 1000;
  localparam int unsigned LOW_MIN_CYC = (LOW_MIN_CYC_RAW < 1) ? 1 : LOW_MIN_CYC_RAW;
  localparam int unsigned SHUTDOWN_CYC = (SHUTDOWN_LOW_NS / 1000) * (CLK_KHZ / 1000);
  localparam int unsigned PUMP_DELAY_CYC = (PUMP_DELAY_NS / 1000) * (CLK_KHZ / 1000);
  localparam int unsigned SETTLE_CYC = (SETTLE_NS / 1000) * (CLK_KHZ / 1000);
  // Counter width covers the longest count
  localparam int unsigned CNT_W = 16;
  // Dimming levels: 0 is full scale, 5 is 3.125 percent
  localparam logic [2:0] DIM_FULL = 3'h0;
  localparam logic [2:0] DIM_LOWEST = 3'h5;
  // Reset values
  localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
  typedef enum logic [1:0] {PDM_GAIN_1X, PDM_GAIN_1X33, PDM_GAIN_1X5, PDM_GAIN_2X} pdm_gain_e;
endpackage

// >>> hw/pdm_sync.sv
// Two flop synchroniser for the dimming pin
`timescale 1ns/10ps
`default_nettype none
module pdm_sync (
  input wire logic clk,
  input wire logic rst,
  input wire logic async_in,
  output logic sync_out
);
  import pdm_pkg::*;
  logic meta_ff;
  logic sync_ff;
  logic nxt_meta;
  logic nxt_sync;
  // Pin idles low, like a shut down host
  always_comb begin
    nxt_meta = async_in;
    nxt_sync = meta_ff;
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
    end else begin
      meta_ff <= nxt_meta;
      sync_ff <= nxt_sync;
    end
  end
  assign sync_out = sync_ff;
endmodule // pdm_sync
`default_nettype wire

// >>> hw/pdm_pump.sv
// Charge pump gain sequencer
`timescale 1ns/10ps
`default_nettype none
module pdm_pump #(
  parameter int unsigned DELAY_CYC = pdm_pkg::PUMP_DELAY_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic active,
  input wire logic regulation_lost,
  input wire logic unity_headroom,
  output pdm_pkg::pdm_gain_e gain
);
  import pdm_pkg::*;
  pdm_gain_e gain_ff;
  pdm_gain_e nxt_gain;
  logic [CNT_W-1:0] dly_ff;
  logic [CNT_W-1:0] nxt_dly;
  // Delay counts only while regulation stays lost; a recovery restarts it
  always_comb begin
    nxt_gain = gain_ff;
    nxt_dly = CNT_RST;
    if (!active) begin
      nxt_gain = PDM_GAIN_1X;
    end else if (unity_headroom && gain_ff != PDM_GAIN_1X) begin
      nxt_gain = PDM_GAIN_1X;
    end else if (regulation_lost && gain_ff != PDM_GAIN_2X) begin
      if (dly_ff >= CNT_W'(DELAY_CYC - 1)) begin
        unique case (gain_ff)
          PDM_GAIN_1X: nxt_gain = PDM_GAIN_1X33;
          PDM_GAIN_1X33: nxt_gain = PDM_GAIN_1X5;
          PDM_GAIN_1X5: nxt_gain = PDM_GAIN_2X;
          PDM_GAIN_2X: nxt_gain = PDM_GAIN_2X;
        endcase
      end else begin
        nxt_dly = dly_ff + 1'b1;
      end
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      gain_ff <= PDM_GAIN_1X;
      dly_ff <= CNT_RST;
    end else begin
      gain_ff <= nxt_gain;
      dly_ff <= nxt_dly;
    end
  end
  assign gain = gain_ff;
endmodule // pdm_pump
`default_nettype wire

// >>> hw/pdm_ctrl.sv
// Top: single pin enable, pulse dimming and pump mode control
`timescale 1ns/10ps
`default_nettype none
module pdm_ctrl #(
  parameter int unsigned SHUTDOWN_CYCLES = pdm_pkg::SHUTDOWN_CYC,
  parameter int unsigned PUMP_DELAY_CYCLES = pdm_pkg::PUMP_DELAY_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic enable_dimming_pin,
  input wire logic regulation_lost,
  input wire logic unity_headroom,
  output logic driver_on,
  output logic [2:0] dim_level,
  output pdm_pkg::pdm_gain_e pump_gain,
  output logic current_settling
);
  import pdm_pkg::*;

  logic pin_s;
  logic pin_d_ff;
  logic nxt_pin_d;
  logic on_ff;
  logic nxt_on;
  logic [CNT_W-1:0] low_ff;
  logic [CNT_W-1:0] nxt_low;
  logic valid_low_ff;
  logic nxt_valid_low;
  logic [2:0] lvl_ff;
  logic [2:0] nxt_lvl;
  logic [CNT_W-1:0] settle_ff;
  logic [CNT_W-1:0] nxt_settle;
  logic busy_ff;
  logic nxt_busy;
  pdm_gain_e gain_w;

  // Pin is asynchronous to clk
  pdm_sync u_sync (
    .clk(clk),
    .rst(rst),
    .async_in(enable_dimming_pin),
    .sync_out(pin_s)
  );

  // Pump runs only while the driver is on
  pdm_pump #(
    .DELAY_CYC(PUMP_DELAY_CYCLES)
  ) u_pump (
    .clk(clk),
    .rst(rst),
    .active(nxt_on), // Same edge as shutdown, so the pump is never left above unity while off
    .regulation_lost(regulation_lost),
    .unity_headroom(unity_headroom),
    .gain(gain_w)
  );

  // Pin decode: wake, low time, dimming edges, shutdown
  always_comb begin
    nxt_pin_d = pin_s;
    nxt_on = on_ff;
    nxt_lvl = lvl_ff;
    nxt_low = low_ff;
    nxt_valid_low = valid_low_ff;
    nxt_settle = settle_ff;
    nxt_busy = busy_ff;
    if (pin_s) begin
      nxt_low = CNT_RST;
      if (!on_ff) begin
        nxt_on = 1'b1;
        nxt_lvl = DIM_FULL;
      end else if (!pin_d_ff && valid_low_ff) begin
        // Short glitches never set the valid flag
        if (lvl_ff != DIM_LOWEST) begin
          nxt_lvl = lvl_ff + 3'h1;
          nxt_settle = CNT_RST;
          nxt_busy = 1'b1;
        end
      end
      nxt_valid_low = 1'b0;
    end else if (on_ff) begin
      // Saturate counter so a stuck low cannot wrap
      if (low_ff != CNT_W'(SHUTDOWN_CYCLES - 1)) begin
        nxt_low = low_ff + 1'b1;
      end else begin
        nxt_on = 1'b0;
        nxt_lvl = DIM_FULL;
        nxt_busy = 1'b0;
      end
      if (low_ff >= CNT_W'(LOW_MIN_CYC - 1)) begin
        nxt_valid_low = 1'b1;
      end
    end
    // Settling window after each dimming step
    if (busy_ff && nxt_settle == settle_ff) begin
      if (settle_ff >= CNT_W'(SETTLE_CYC - 1)) begin
        nxt_busy = 1'b0;
      end else begin
        nxt_settle = settle_ff + 1'b1;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pin_d_ff <= 1'b0;
      on_ff <= 1'b0;
      lvl_ff <= DIM_FULL;
      low_ff <= CNT_RST;
      valid_low_ff <= 1'b0;
      settle_ff <= CNT_RST;
      busy_ff <= 1'b0;
    end else begin
      pin_d_ff <= nxt_pin_d;
      on_ff <= nxt_on;
      lvl_ff <= nxt_lvl;
      low_ff <= nxt_low;
      valid_low_ff <= nxt_valid_low;
      settle_ff <= nxt_settle;
      busy_ff <= nxt_busy;
    end
  end

  assign driver_on = on_ff;
  assign dim_level = lvl_ff;
  assign pump_gain = gain_w;
  assign current_settling = busy_ff;
endmodule // pdm_ctrl
`default_nettype wire

// >>> sim/pdm_ctrl_sva.sv
// Port checker for the dimming and pump controller
`timescale 1ns/10ps
`default_nettype none
module pdm_ctrl_sva #(
  parameter int unsigned SHUTDOWN_CYCLES = pdm_pkg::SHUTDOWN_CYC,
  parameter int unsigned PUMP_DELAY_CYCLES = pdm_pkg::PUMP_DELAY_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic enable_dimming_pin,
  input wire logic regulation_lost,
  input wire logic driver_on,
  input wire logic [2:0] dim_level,
  input wire pdm_pkg::pdm_gain_e pump_gain,
  input wire logic current_settling
);
  import pdm_pkg::*;
  logic [15:0] low_ff, nxt_low;
  // Raw low run; sync lag makes it lead the design's count
  always_comb nxt_low = enable_dimming_pin ? 16'h0000 : low_ff + 16'h0001;
  always_ff @(posedge clk or posedge rst) low_ff <= rst ? 16'h0000 : nxt_low;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  gain_step_a: assert property (pump_gain > $past(pump_gain) |->
    pump_gain == $past(pump_gain) + 2'h1) else $error("gain skipped");
  gain_down_a: assert property (pump_gain < $past(pump_gain) |->
    pump_gain == PDM_GAIN_1X) else $error("gain fell short of unity");
  gain_wait_a: assert property (pump_gain > $past(pump_gain) |->
    $past(regulation_lost, 40)) else $error("gain rose early");
  dim_step_a: assert property (dim_level > $past(dim_level) |->
    dim_level == $past(dim_level) + 3'h1) else $error("dim skipped");
  dim_floor_a: assert property (dim_level <= DIM_LOWEST) else $error("dim past floor");
  settle_a: assert property (dim_level > $past(dim_level) |->
    ##2 current_settling [*8]) else $error("settle flag missing");
  off_clear_a: assert property (!driver_on |->
    dim_level == DIM_FULL && pump_gain == PDM_GAIN_1X) else $error("off state dirty");
  shut_a: assert property ($fell(driver_on) |->
    low_ff >= SHUTDOWN_CYCLES - 2) else $error("early shutdown");
  wake_a: assert property ($rose(driver_on) |->
    $past(enable_dimming_pin, 2)) else $error("wake without pin");
endmodule // pdm_ctrl_sva
bind pdm_ctrl pdm_ctrl_sva #(.SHUTDOWN_CYCLES(SHUTDOWN_CYCLES),
  .PUMP_DELAY_CYCLES(PUMP_DELAY_CYCLES)) chk (.clk(clk), .rst(rst),
  .enable_dimming_pin(enable_dimming_pin), .regulation_lost(regulation_lost),
  .driver_on(driver_on), .dim_level(dim_level),
  .pump_gain(pump_gain), .current_settling(current_settling));
`default_nettype wire

// >>> sim/pdm_host.sv
// Host pin model driving the enable and dimming input
`timescale 1ns/10ps
`default_nettype none
module pdm_host (
  input wire logic clk,
  output logic pin
);
  initial pin = 1'b0;
  // Raise pin and wait out the wake setup before any pulse
  task automatic wake();
    @(negedge clk) pin = 1'b1;
    repeat (260) @(negedge clk);
  endtask
  // Low phase of lo cycles, then a high phase
  task automatic pulse(input int lo);
    @(negedge clk) pin = 1'b0;
    repeat (lo) @(negedge clk);
    pin = 1'b1;
    repeat (10) @(negedge clk);
  endtask
  // Long low to force shutdown
  task automatic sleep(input int n);
    @(negedge clk) pin = 1'b0;
    repeat (n) @(negedge clk);
  endtask
endmodule // pdm_host
`default_nettype wire

// >>> sim/pdm_ctrl_test.sv
// Self-checking bench for the dimming and pump controller
`timescale 1ns/10ps
`default_nettype none
module pdm_ctrl_test;
  import pdm_pkg::*;
  logic clk = 0, rst = 1, lost = 0, head = 0, drv, setl;
  wire logic pin;
  logic [2:0] dim;
  pdm_gain_e gain;
  int error_cnt = 0, n_compared = 0;
  // 25 MHz clock
  always #20 clk = ~clk;
  pdm_host host (.clk(clk), .pin(pin));
  pdm_ctrl #(.SHUTDOWN_CYCLES(200), .PUMP_DELAY_CYCLES(50)) uut (.clk(clk), .rst(rst),
    .enable_dimming_pin(pin), .regulation_lost(lost), .unity_headroom(head),
    .driver_on(drv), .dim_level(dim), .pump_gain(gain), .current_settling(setl));
  task automatic chk(input logic [5:0] got, input logic [5:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  // Short glitch, then six counted pulses, last one at the floor
  task automatic t_dim();
    host.pulse(2);
    chk(dim, DIM_FULL);
    for (int i = 1; i <= 6; i++) begin
      host.pulse(5);
      chk(setl, 1'b1);
      chk(dim, 6'((i > 5) ? 5 : i));
    end
    tick(1010);
    chk(setl, 1'b0);
  endtask
  // Escalate one step per delay, then drop straight to unity
  task automatic t_pump();
    lost = 1'b1;
    tick(40);
    chk(gain, PDM_GAIN_1X);
    tick(20);
    chk(gain, PDM_GAIN_1X33);
    tick(55);
    chk(gain, PDM_GAIN_1X5);
    tick(110);
    chk(gain, PDM_GAIN_2X);
    head = 1'b1;
    tick(3);
    chk(gain, PDM_GAIN_1X);
    lost = 1'b0;
    head = 1'b0;
  endtask
  task automatic print_verdict();
    $display("compared %0d errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Watchdog well beyond the expected run
  initial begin
    #400000;
    error_cnt++;
    print_verdict();
  end
  initial begin
    tick(2);
    rst = 1'b0;
    chk({drv, dim, gain}, 6'h00);
    host.wake();
    chk({drv, dim, gain}, 6'h20);
    t_pump();
    t_dim();
    host.sleep(250);
    chk({drv, dim, gain}, 6'h00);
    host.wake();
    chk({drv, dim, gain}, 6'h20);
    print_verdict();
  end
endmodule // pdm_ctrl_test
`default_nettype wire
